// [design/psd_cfg.svh]
`ifndef PSD_CFG_SVH
`define PSD_CFG_SVH
// Register byte offsets on the bus
`define PSD_CTRL_OFFS 8'h00
`define PSD_STATUS_OFFS 8'h04
// Control register fields
`define PSD_CTRL_PAUSE_BIT 0
`define PSD_CTRL_RST 32'h0000_0000
// Status register fields
`define PSD_ST_CNT_LSB 0
`define PSD_ST_ACT_BIT 2
`define PSD_ST_WR_BIT 3
`define PSD_ST_SLEEP_BIT 4
`define PSD_ST_ILV_BIT 5
`define PSD_ST_WRDY_BIT 6
`define PSD_ST_LVL_LSB 8
// Bus answers
`define PSD_RESP_OKAY 2'h0
`define PSD_RESP_SLVERR 2'h2
// Burst counter width and write queue depth
`define PSD_BURST_W 2
`define PSD_FIFO_DEPTH 4
`endif

// [design/psd_pkg.sv]
package psd_pkg;
  // Access phase of the data port
  typedef enum logic [2:0] {
    PSD_IDLE = 3'b001,
    PSD_READ = 3'b010,
    PSD_WRITE = 3'b100
  } psd_acc_t;
  // Burst offset inside a four-word group
  typedef logic [1:0] psd_step_t;
endpackage : psd_pkg

// [design/psd_sram_port.sv]
// What this block and its party do
// [RL1] Sleep high holds every stored word intact
// [RL2] Party keeps sleep low for normal use
// [RL3] Data and parity captured on rising edge
// [RL4] Read data driven one cycle after address
// [RL5] Enable low drives data and parity lines
// [RL6] Enable high releases all lines to inputs
// [RL7] Strap low gives linear burst order
// [RL8] Strap high or floating gives interleaved order; here a floating strap holds its reset low, giving linear
// [RL9] Party keeps burst strap constant
// [RL10] Scan output changes on test clock fall
// [RL11] First read clock after deselect stays released
// [RL12] Step input low advances burst counter
// [RL13] Two-bit wrapping counter forms burst addresses
// [RL14] Interleaved is start XOR step, linear adds
// [RL15] Party issues no access while sleeping
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`include "psd_cfg.svh"

// Small synchronous FIFO with valid/ready on both sides
module psd_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady,
  output logic [$clog2(DEPTH):0] level
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH]; // Entry storage
  logic [PW-1:0] wrPtr_r; // Next free entry
  logic [PW-1:0] rdPtr_r; // Oldest entry
  logic [PW:0] count_r; // Entries held
  logic doPush;
  logic doPop;
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;
  assign inReady = (count_r != (PW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData = store[rdPtr_r];
  assign level = count_r;
  // Entry write, no reset needed
  always_ff @(posedge ref_clk) begin
    if (doPush) begin
      store[wrPtr_r] <= inData;
    end
  end
  // Pointers and fill count
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (doPush) begin
        wrPtr_r <= (wrPtr_r == PW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
      end
      if (doPop) begin
        rdPtr_r <= (rdPtr_r == PW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
      end
      count_r <= count_r + (PW+1)'(doPush) - (PW+1)'(doPop);
    end
  end
endmodule : psd_fifo

// Data side of the pipelined burst memory
module psd_sram_port import psd_pkg::*; #(
  parameter int DATA_W = 32,
  parameter int PAR_W = 4,
  parameter int ADDR_W = 8,
  parameter int FIFO_DEPTH = `PSD_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  // Access control from the cache controller, same clock
  input wire logic chipSelectPrimaryN,
  input wire logic processorAddrStrobeN,
  input wire logic writeN,
  input wire logic burstStepN,
  input wire logic [ADDR_W-1:0] addr,
  // Asynchronous pins
  input wire logic outputEnableN,
  input wire logic sleepRequest,
  input wire logic burstModeStrap,
  // Shared data and parity lines, and write readiness
  input wire logic [DATA_W-1:0] dataIoI,
  output logic [DATA_W-1:0] dataIoO,
  output logic [DATA_W-1:0] dataIoOe,
  input wire logic [PAR_W-1:0] parityIoLinesI,
  output logic [PAR_W-1:0] parityIoLinesO,
  output logic [PAR_W-1:0] parityIoLinesOe,
  output logic writeReady,
  // Scan pins
  input wire logic testClk,
  input wire logic testDataIn,
  output logic testDataOut,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int WW = DATA_W + PAR_W; // Stored word width
  localparam int FW = ADDR_W + WW; // Queued write width
  localparam int LW = $clog2(FIFO_DEPTH) + 1;
  localparam int NS = 5; // Synchronised pins
  // Reset levels match idle pins except the strap, reset low, so a high strap changes after reset
  localparam logic [NS-1:0] PIN_RST = 5'h01;

  // Three-stage pin synchronisers with agreement filter
  logic [NS-1:0] pinRaw;
  logic [NS-1:0] syncA_r;
  logic [NS-1:0] syncB_r;
  logic [NS-1:0] syncC_r;
  logic [NS-1:0] pinLvl_r; // Filtered levels
  assign pinRaw = {testDataIn, testClk, burstModeStrap, sleepRequest,
    outputEnableN};
  generate
    for (genvar i = 0; i < NS; i++) begin : g_sync
      // Level moves only when the last two stages agree
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          syncA_r[i] <= PIN_RST[i];
          syncB_r[i] <= PIN_RST[i];
          syncC_r[i] <= PIN_RST[i];
          pinLvl_r[i] <= PIN_RST[i];
        end else begin
          syncA_r[i] <= pinRaw[i];
          syncB_r[i] <= syncA_r[i];
          syncC_r[i] <= syncB_r[i];
          if (syncB_r[i] == syncC_r[i]) begin
            pinLvl_r[i] <= syncC_r[i];
          end
        end
      end
    end
  endgenerate
  logic oeHigh; // Lines released
  logic sleeping; // Low-activity hold
  logic interleave; // Burst order
  logic tckLvl;
  logic tdiLvl;
  assign oeHigh = pinLvl_r[0];
  assign sleeping = pinLvl_r[1]; // Low or floating means awake, see [RL2]
  assign interleave = pinLvl_r[2]; // Strap held static, see [RL9]
  assign tckLvl = pinLvl_r[3];
  assign tdiLvl = pinLvl_r[4];

  // Access sequencing
  psd_acc_t acc_r; // Current access phase
  logic [ADDR_W-1:0] base_r; // Start address of burst
  psd_step_t step_r; // Burst step count
  psd_step_t curLow; // Low address bits now
  logic [ADDR_W-1:0] curAddr;
  logic startAcc; // New access this edge
  logic deselect;
  logic fromDesel; // Start out of deselected state
  logic stepNow;
  // Sleeping blocks new strobes, see [RL15]
  assign startAcc = !sleeping && !chipSelectPrimaryN
    && !processorAddrStrobeN;
  assign deselect = chipSelectPrimaryN && !processorAddrStrobeN;
  assign fromDesel = startAcc && (acc_r == PSD_IDLE);
  assign stepNow = (acc_r != PSD_IDLE) && !startAcc && !burstStepN;
  // Burst order selection, see [RL7] [RL8] [RL14]
  assign curLow = interleave ? (base_r[1:0] ^ step_r)
    : (base_r[1:0] + step_r);
  assign curAddr = {base_r[ADDR_W-1:2], curLow};
  // Phase, base address and wrapping step counter
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_r <= PSD_IDLE;
      base_r <= '0;
      step_r <= '0;
    end else if (sleeping || deselect) begin
      acc_r <= PSD_IDLE;
    end else if (startAcc) begin
      acc_r <= writeN ? PSD_READ : PSD_WRITE;
      base_r <= addr; // First address loaded, see [RL13]
      step_r <= '0;
    end else if (stepNow) begin
      step_r <= step_r + 2'd1; // Wraps after four, see [RL12] [RL13]
    end
  end

  // Memory array and read pipeline
  logic [WW-1:0] mem [2**ADDR_W]; // Stored words
  logic [WW-1:0] memWord;
  logic memWe;
  logic [FW-1:0] drainData;
  assign memWord = mem[curAddr];
  logic [DATA_W-1:0] dataOut_r;
  logic [PAR_W-1:0] parOut_r;
  logic drive_r;
  logic readNow;
  assign readNow = (acc_r == PSD_READ) && !sleeping && !deselect;
  // Word fetched from the address held since last edge, see [RL4]
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dataOut_r <= '0;
      parOut_r <= '0;
    end else if (readNow) begin
      {parOut_r, dataOut_r} <= memWord;
    end
  end
  // Line direction from the output enable level
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      drive_r <= 1'b0;
    end else if (fromDesel || oeHigh) begin
      drive_r <= 1'b0; // Masked first clock, see [RL11]; released, [RL6]
    end else begin
      drive_r <= readNow; // Driven while enable low, see [RL5]
    end
  end
  assign dataIoO = dataOut_r;
  assign parityIoLinesO = parOut_r;
  assign dataIoOe = {DATA_W{drive_r}};
  assign parityIoLinesOe = {PAR_W{drive_r}};

  // Input capture register and write queue
  logic [WW-1:0] capWord_r; // Captured lines
  logic [ADDR_W-1:0] capAddr_r;
  logic capValid_r;
  logic fifoInReady;
  logic fifoOutValid;
  logic [LW-1:0] fifoLvl;
  logic [31:0] ctrl_r;
  logic drainReady;
  logic wrReady_r;
  // Lines sampled every rising edge, see [RL3]
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      capWord_r <= '0;
      capAddr_r <= '0;
      capValid_r <= 1'b0;
    end else begin
      capWord_r <= {parityIoLinesI, dataIoI};
      capAddr_r <= curAddr;
      capValid_r <= (acc_r == PSD_WRITE) && !startAcc && !sleeping
        && !deselect && fifoInReady;
    end
  end
  // Drain stalls in sleep or on software pause, see [RL1]
  assign drainReady = !sleeping && !ctrl_r[`PSD_CTRL_PAUSE_BIT];
  assign memWe = fifoOutValid && drainReady;
  psd_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_wrq (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .inData({capAddr_r, capWord_r}),
    .inValid(capValid_r),
    .inReady(fifoInReady),
    .outData(drainData),
    .outValid(fifoOutValid),
    .outReady(drainReady),
    .level(fifoLvl)
  );
  // Array update from the queue head
  always_ff @(posedge ref_clk) begin
    if (memWe) begin
      mem[drainData[FW-1:WW]] <= drainData[WW-1:0];
    end
  end
  // Write readiness toward the controller
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrReady_r <= 1'b0;
    end else begin
      wrReady_r <= (fifoLvl < LW'(FIFO_DEPTH - 1));
    end
  end
  assign writeReady = wrReady_r;

  // Scan shifter, shift on rise and present on fall
  logic tckPrev_r;
  logic [3:0] scan_r;
  logic tdo_r;
  logic tckFall;
  assign tckFall = tckPrev_r && !tckLvl;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tckPrev_r <= 1'b0;
      scan_r <= '0;
      tdo_r <= 1'b0;
    end else begin
      tckPrev_r <= tckLvl;
      if (!tckPrev_r && tckLvl) begin
        scan_r <= {tdiLvl, scan_r[3:1]};
      end
      if (tckFall) begin
        tdo_r <= scan_r[0]; // Output moves on falling edge, see [RL10]
      end
    end
  end
  assign testDataOut = tdo_r;

  // AXI4-Lite write channel
  logic awReady_r; // Address slot free
  logic wReady_r; // Data slot free
  logic [7:0] awAddr_r;
  logic [31:0] wData_r;
  logic bValid_r;
  logic [1:0] bResp_r;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      awReady_r <= 1'b1;
      wReady_r <= 1'b1;
      awAddr_r <= '0;
      wData_r <= '0;
      bValid_r <= 1'b0;
      bResp_r <= `PSD_RESP_OKAY;
      ctrl_r <= `PSD_CTRL_RST;
    end else begin
      if (s_axi_awvalid && awReady_r) begin
        awReady_r <= 1'b0;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wReady_r) begin
        wReady_r <= 1'b0;
        wData_r <= s_axi_wdata;
      end
      if (!awReady_r && !wReady_r && !bValid_r) begin
        bValid_r <= 1'b1;
        awReady_r <= 1'b1;
        wReady_r <= 1'b1;
        if (awAddr_r == `PSD_CTRL_OFFS) begin
          bResp_r <= `PSD_RESP_OKAY;
          ctrl_r[`PSD_CTRL_PAUSE_BIT] <= wData_r[`PSD_CTRL_PAUSE_BIT];
        end else begin
          bResp_r <= (awAddr_r == `PSD_STATUS_OFFS) ? `PSD_RESP_OKAY
            : `PSD_RESP_SLVERR;
        end
      end else if (bValid_r && s_axi_bready) begin
        bValid_r <= 1'b0;
      end
    end
  end
  assign s_axi_awready = awReady_r;
  assign s_axi_wready = wReady_r;
  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;

  // AXI4-Lite read channel
  logic rValid_r;
  logic arReady_r; // Request slot free, inverse of rValid_r
  logic [31:0] rData_r;
  logic [1:0] rResp_r;
  logic [31:0] status;
  always_comb begin
    status = '0;
    status[`PSD_ST_CNT_LSB +: 2] = step_r;
    status[`PSD_ST_ACT_BIT] = (acc_r != PSD_IDLE);
    status[`PSD_ST_WR_BIT] = (acc_r == PSD_WRITE);
    status[`PSD_ST_SLEEP_BIT] = sleeping;
    status[`PSD_ST_ILV_BIT] = interleave;
    status[`PSD_ST_WRDY_BIT] = wrReady_r;
    status[`PSD_ST_LVL_LSB +: LW] = fifoLvl;
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rValid_r <= 1'b0;
      arReady_r <= 1'b1;
      rData_r <= '0;
      rResp_r <= `PSD_RESP_OKAY;
    end else if (s_axi_arvalid && arReady_r) begin
      rValid_r <= 1'b1;
      arReady_r <= 1'b0;
      rResp_r <= `PSD_RESP_OKAY;
      if (s_axi_araddr == `PSD_CTRL_OFFS) begin
        rData_r <= ctrl_r;
      end else if (s_axi_araddr == `PSD_STATUS_OFFS) begin
        rData_r <= status;
      end else begin
        rData_r <= '0;
        rResp_r <= `PSD_RESP_SLVERR;
      end
    end else if (rValid_r && s_axi_rready) begin
      rValid_r <= 1'b0;
      arReady_r <= 1'b1;
    end
  end
  assign s_axi_arready = arReady_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;

  // Checks
  sequence readIssued;
    readNow && !oeHigh && !fromDesel;
  endsequence
  sequence linesDriven;
    dataIoOe[0] && parityIoLinesOe[0];
  endsequence
  sleepHold_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    sleeping |-> !memWe) else $error("array written in sleep"); // see [RL1]
  lineCapture_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    1'b1 |=> capWord_r == $past({parityIoLinesI, dataIoI}))
    else $error("lines not captured"); // see [RL3]
  readLatency_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    readNow |=> {parityIoLinesO, dataIoO} == $past(memWord))
    else $error("read data wrong"); // see [RL4]
  oeDrive_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    readIssued |=> linesDriven) else $error("lines not driven"); // see [RL5]
  oeRelease_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    oeHigh |=> !dataIoOe[0] && !parityIoLinesOe[0])
    else $error("lines driven while released"); // see [RL6]
  orderLinear_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !interleave && (acc_r != PSD_IDLE) |->
    curAddr[1:0] == 2'(base_r[1:0] + step_r))
    else $error("linear order wrong"); // see [RL7]
  orderIlv_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    interleave && (acc_r != PSD_IDLE) |->
    curAddr[1:0] == (base_r[1:0] ^ step_r))
    else $error("interleaved order wrong"); // see [RL8]
  tdoFall_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $changed(testDataOut) |-> $past(tckFall))
    else $error("scan output moved off fall"); // see [RL10]
  firstMask_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    fromDesel |=> !dataIoOe[0]) else $error("first read driven"); // see [RL11]
  burstStep_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    stepNow && !sleeping && !deselect |=> step_r == 2'($past(step_r) + 1))
    else $error("burst step missed"); // see [RL12]
  burstWrap_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    startAcc && !deselect ##1 (stepNow && !sleeping && !deselect) [*4]
    |=> step_r == 2'd0) else $error("counter did not wrap"); // see [RL13]
endmodule : psd_sram_port

// [bench/psd_bus_partner.sv]
`timescale 1ns/10ps
// Controller side of the shared data and parity lines
module psd_bus_partner (
  input wire logic ref_clk,
  input wire logic drive, // Controller presents write data
  input wire logic [31:0] hostData,
  input wire logic [3:0] hostPar,
  input wire logic [31:0] dutData,
  input wire logic [31:0] dutOe,
  input wire logic [3:0] dutPar,
  input wire logic [3:0] dutParOe,
  output logic [31:0] lineData,
  output logic [3:0] linePar
);
  // Line levels of the previous cycle; start known so lines never float X
  logic [31:0] lastData_r = '0;
  logic [3:0] lastPar_r = '0;
  // Remember what the lines carried
  always @(posedge ref_clk) begin
    lastData_r <= lineData;
    lastPar_r <= linePar;
  end
  // Resolve lines; a floating line shows the inverse of its last level
  always_comb begin
    lineData = (dutOe & dutData) |
      (~dutOe & (drive ? hostData : ~lastData_r));
    linePar = (dutParOe & dutPar) |
      (~dutParOe & (drive ? hostPar : ~lastPar_r));
    // Both ends driving is a clash
    if (drive && ((|dutOe) || (|dutParOe))) begin
      lineData = 'x;
      linePar = 'x;
    end
  end
endmodule : psd_bus_partner

// [bench/testbench.sv]
`timescale 1ns/10ps
`include "psd_cfg.svh"
module testbench;
  localparam logic [31:0] PAT = 32'hA5C3_0000; // Write data pattern
  logic ref_clk;
  logic arst_n;
  logic csN, strN, wrN, stepN, oeN, sleep, strap, tClk, tDin, tDout, tv;
  logic hostDrv, wRdy;
  logic [7:0] addr, awaddr, araddr;
  logic [31:0] hostData, dIn, dOut, dOe, wdata, rdata, r, sData, sOe;
  logic [3:0] pIn, pOut, pOe, hostPar, sPar, sParOe;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  int miscompares, checked;

  psd_sram_port DUT (.ref_clk(ref_clk), .arst_n(arst_n),
    .chipSelectPrimaryN(csN), .processorAddrStrobeN(strN), .writeN(wrN),
    .burstStepN(stepN), .addr(addr), .outputEnableN(oeN),
    .sleepRequest(sleep), .burstModeStrap(strap), .dataIoI(dIn),
    .dataIoO(dOut), .dataIoOe(dOe), .parityIoLinesI(pIn),
    .parityIoLinesO(pOut), .parityIoLinesOe(pOe), .writeReady(wRdy),
    .testClk(tClk), .testDataIn(tDin), .testDataOut(tDout),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  psd_bus_partner bus (.ref_clk(ref_clk), .drive(hostDrv),
    .hostData(hostData), .hostPar(hostPar), .dutData(dOut), .dutOe(dOe),
    .dutPar(pOut), .dutParOe(pOe), .lineData(dIn), .linePar(pIn));

  // 25 MHz clock
  always #20 ref_clk = ~ref_clk;

  // Print counts and verdict, then stop
  task final_report;
    $display("Counts: checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  // Compare one value
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask : chk

  // One memory-port cycle; snapshot outputs of the edge just passed
  task cyc(input logic c, input logic s, input logic w, input logic v,
    input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    csN <= c;
    strN <= s;
    wrN <= w;
    stepN <= v;
    addr <= a;
    hostDrv <= ~w;
    hostData <= d;
    hostPar <= d[3:0] ^ 4'h9;
    #1;
    sData = dOut;
    sOe = dOe;
    sPar = pOut;
    sParOe = pOe;
  endtask : cyc

  // Idle cycles, no access
  task idle(input int n);
    repeat (n) cyc(1'b1, 1'b1, 1'b1, 1'b1, 8'h00, 32'h0000_0000);
  endtask : idle

  // Change the asynchronous pins, then let them settle
  task pins(input logic o, input logic s, input logic m);
    @(posedge ref_clk);
    oeN <= o;
    sleep <= s;
    strap <= m;
    idle(6);
  endtask : pins

  // Four-word write burst, then deselect
  task wr_burst(input logic [7:0] base);
    cyc(1'b0, 1'b0, 1'b0, 1'b1, base, 32'h0000_0000);
    for (int i = 0; i < 5; i++)
      cyc(1'b1, i != 4, 1'b0, i >= 4, 8'h00, PAT + (i > 3 ? 3 : i));
    idle(10);
  endtask : wr_burst

  // Four-word linear read burst from idle, then deselect
  task rd_burst(input logic [7:0] base, input bit oeOn, input bit dChk);
    logic [31:0] e;
    logic [31:0] ep;
    logic [31:0] eOe;
    eOe = oeOn ? 32'hFFFF_FFFF : 32'h0000_0000;
    cyc(1'b0, 1'b0, 1'b1, 1'b1, base, 32'h0000_0000);
    cyc(1'b1, 1'b1, 1'b1, 1'b0, 8'h00, 32'h0000_0000);
    // Cycle after the start edge stays released
    chk("first clock enable", 32'h0000_0000, sOe);
    for (int i = 0; i < 5; i++) begin
      cyc(1'b1, i != 3, 1'b1, i >= 2, 8'h00, 32'h0000_0000);
      e = PAT + (((base + i) & 3) ^ 1); // Written in interleaved order
      ep = {28'h0, e[3:0] ^ 4'h9};
      if (i < 4) begin
        if (dChk) begin
          chk("read data", e, sData);
          chk("read parity", ep, {28'h0, sPar});
        end
        chk("data enable", eOe, sOe);
        chk("parity enable", eOe & 32'hF, {28'h0, sParOe});
      end else chk("enable after deselect", 32'h0000_0000, sOe);
    end
  endtask : rd_burst

  // Register write over the bus
  task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit done;
    done = 0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        done = 1;
        chk("write response", {30'h0, er}, {30'h0, bresp});
      end
    end
    if (!done) begin
      miscompares++;
      final_report();
    end
  endtask : axi_wr

  // Register read over the bus
  task axi_rd(input logic [7:0] a, output logic [31:0] d,
    input logic [1:0] er);
    bit done;
    done = 0;
    d = 32'h0000_0000;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        rready <= 1'b0;
        done = 1;
        chk("read response", {30'h0, er}, {30'h0, rresp});
      end
    end
    if (!done) begin
      miscompares++;
      final_report();
    end
  endtask : axi_rd

  // Main sequence
  initial begin
    ref_clk = 0; arst_n = 0; csN = 1; strN = 1; wrN = 1; stepN = 1;
    addr = 0; oeN = 1; sleep = 0; strap = 1; tClk = 0; tDin = 0;
    hostDrv = 0; hostData = 0; hostPar = 0; awaddr = 0; wdata = 0;
    awvalid = 0; wvalid = 0; bready = 0; araddr = 0; arvalid = 0;
    rready = 0; miscompares = 0; checked = 0;
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    idle(8);
    chk("write ready", 32'h0000_0001, {31'h0, wRdy});
    axi_rd(`PSD_STATUS_OFFS, r, `PSD_RESP_OKAY);
    chk("status after reset", 32'h0000_0060, r & 32'h0000_0770);
    axi_rd(`PSD_CTRL_OFFS, r, `PSD_RESP_OKAY);
    chk("control reset", `PSD_CTRL_RST, r);
    axi_wr(`PSD_CTRL_OFFS, 32'h0000_0001, `PSD_RESP_OKAY);
    axi_rd(`PSD_CTRL_OFFS, r, `PSD_RESP_OKAY);
    chk("control readback", 32'h0000_0001, r);
    axi_wr(`PSD_CTRL_OFFS, 32'h0000_0000, `PSD_RESP_OKAY);
    axi_rd(8'h08, r, `PSD_RESP_SLVERR);
    chk("unmapped read", 32'h0000_0000, r);
    axi_wr(8'h0C, 32'h0000_0001, `PSD_RESP_SLVERR);
    wr_burst(8'h11);
    pins(1'b0, 1'b0, 1'b0);
    axi_rd(`PSD_STATUS_OFFS, r, `PSD_RESP_OKAY);
    chk("status linear", 32'h0000_0040, r & 32'h0000_0770);
    rd_burst(8'h12, 1'b1, 1'b1);
    pins(1'b1, 1'b0, 1'b0);
    rd_burst(8'h10, 1'b0, 1'b0);
    pins(1'b1, 1'b1, 1'b0);
    axi_rd(`PSD_STATUS_OFFS, r, `PSD_RESP_OKAY);
    chk("status sleeping", 32'h0000_0050, r & 32'h0000_0770);
    pins(1'b0, 1'b0, 1'b0);
    rd_burst(8'h10, 1'b1, 1'b1);
    // Scan output holds across a rise and moves after a fall
    for (int k = 0; k < 8; k++) begin
      tv = tDout;
      @(posedge ref_clk);
      tDin <= k[0];
      tClk <= 1'b1;
      idle(6);
      chk("scan out on rise", {31'h0, tv}, {31'h0, tDout});
      @(posedge ref_clk);
      tClk <= 1'b0;
      idle(6);
      tv = (k >= 3) ? !k[0] : 1'b0; // Bit shifted in three rises earlier
      chk("scan out on fall", {31'h0, tv}, {31'h0, tDout});
    end
    final_report();
  end
endmodule : testbench
